/* cpd_datapath.sv */
// module: cable phy datapath between link controller and three ports
`timescale 1ns/100ps
// Function
// - all timing comes from one 24.576 MHz reference, crystal or clock.
// - a 393.216 MHz pll reference is divided to pace encoded line output.
// - a 49.152 MHz system clock goes to the link and retimes rx data.
// - power-down high halts the pll and every derived clock.
// - isolation select high drives normal levels, low differentiates.
// - link presents 2, 4 or 8 bits, latched on the system clock.
// - latched bits are serialized, encoded and sent at S100/S200/S400.
// - transmit drives data on the tpb pair and strobe on the tpa pair.
// - a receiving port has both transmitters off, receivers on.
// - receive takes data from tpa, strobe from tpb, and recovers bits.
// - received bits split into 2/4/8-bit words, retimed to the link.
// - every received packet is repeated on other connected ports.
// - comparators report line states used for arbitration status.
// - tpa common mode during arbitration picks the next packet speed.
// - tpb common mode shows remote bias, meaning an active connection.
// - each port has its own independently controlled bias output.
module cpd_datapath
  import cpd_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 POWER_DOWN_INPUT,
  input  wire logic                 ISO_SELECT,
  input  wire logic [PORTS-1:0]     BIAS_ENABLE,
  input  wire logic                 LINK_TX_EN,
  input  wire logic [WORD_W-1:0]    LINK_TX_DATA,
  input  wire logic [1:0]           LINK_TX_SPEED,
  input  wire logic [2*PORTS-1:0]   TPA_DATA_I,
  input  wire logic [2*PORTS-1:0]   TPB_STRB_I,
  input  wire logic [PORTS-1:0]     RX_FRAME_I,
  input  wire logic [2*PORTS-1:0]   TPA_LINE_I,
  input  wire logic [2*PORTS-1:0]   TPB_LINE_I,
  input  wire logic [2*PORTS-1:0]   TPA_CM_I,
  input  wire logic [PORTS-1:0]     TPB_BIAS_I,
  output logic                      SYSCLK,
  output logic                      LINK_TX_READY,
  output logic [WORD_W-1:0]         LINK_RX_DATA,
  output logic                      LINK_RX_VALID,
  output logic [1:0]                LINK_RX_SPEED,
  output logic [LANES-1:0]          TPB_DATA_O,
  output logic [LANES-1:0]          TPA_STRB_O,
  output logic [LANES-1:0]          TX_LANE_VLD,
  output logic [PORTS-1:0]          TPA_OE,
  output logic [PORTS-1:0]          TPB_OE,
  output logic [PORTS-1:0]          TPBIAS_EN,
  output logic [PORTS-1:0]          CONNECTED,
  output logic [2*PORTS-1:0]        ARB_STATUS
);

  localparam int SYNC_W = 3 + PORTS * 13 + WORD_W + 2;
  localparam int PTR_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

  // ==========================================================
  // parameter check
  if (DEPTH != 2 && DEPTH != 4)
    $error("DEPTH must be 2 or 4");

  // ==========================================================
  // pin synchronisers: two flops before any logic
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              pd;
  logic              iso;
  logic [PORTS-1:0]  bias_en;
  logic              ltx_en;
  logic [7:0]        ltx_data;
  logic [1:0]        ltx_speed;
  logic [5:0]        rx_d;
  logic [5:0]        rx_s;
  logic [2:0]        rx_frame;
  logic [5:0]        tpa_line;
  logic [5:0]        tpb_line;
  logic [5:0]        tpa_cm;
  logic [2:0]        tpb_bias;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {POWER_DOWN_INPUT, ISO_SELECT, BIAS_ENABLE, LINK_TX_EN,
                 LINK_TX_DATA, LINK_TX_SPEED, TPA_DATA_I, TPB_STRB_I,
                 RX_FRAME_I, TPA_LINE_I, TPB_LINE_I, TPA_CM_I, TPB_BIAS_I};
      sync_b <= sync_a;
    end
  end

  assign {pd, iso, bias_en, ltx_en, ltx_data, ltx_speed, rx_d, rx_s,
          rx_frame, tpa_line, tpb_line, tpa_cm, tpb_bias} = sync_b;

  // ==========================================================
  // clock generation: phase accumulators stand in for the pll
  logic [NCO_W-1:0] acc_sys;
  logic [NCO_W-1:0] acc_slot;
  logic [NCO_W-1:0] next_acc_sys;
  logic [NCO_W-1:0] next_acc_slot;
  logic             sys_carry;
  logic             slot_carry;
  logic             sysclk_q;
  logic             next_sysclk;
  logic             half;
  logic             next_half;
  logic             sys_tick;
  logic             slot_tick;

  // phase steps, held still while powered down
  always_comb begin
    {sys_carry, next_acc_sys}   = {1'b0, acc_sys} + {1'b0, SYS_INC};
    {slot_carry, next_acc_slot} = {1'b0, acc_slot} + {1'b0, SLOT_INC};
    next_sysclk = sysclk_q ^ sys_carry;
    next_half   = half ^ slot_carry;
    if (pd) begin
      next_acc_sys  = acc_sys;
      next_acc_slot = acc_slot;
      next_sysclk   = 1'b0;
      next_half     = half;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_sys  <= '0;
      acc_slot <= '0;
      sysclk_q <= 1'b0;
      half     <= 1'b0;
    end else begin
      acc_sys  <= next_acc_sys;
      acc_slot <= next_acc_slot;
      sysclk_q <= next_sysclk;
      half     <= next_half;
    end
  end

  assign sys_tick  = sys_carry & ~sysclk_q & ~pd;
  assign slot_tick = slot_carry & ~pd;

  // ==========================================================
  // receive: port select, data-strobe decode, deserialize
  logic [PORTS-1:0] rx_onehot;
  logic [1:0]       rx_port;
  logic             rx_busy;
  logic             rx_busy_q;
  logic             prev_par;
  logic             next_prev_par;
  logic [1:0]       rx_speed;
  logic [1:0]       next_rx_speed;
  logic [1:0]       cur_speed;
  logic [7:0]       dreg;
  logic [7:0]       next_dreg;
  logic [3:0]       dcnt;
  logic [3:0]       next_dcnt;
  logic [7:0]       hold;
  logic [7:0]       next_hold;
  logic             pend;
  logic             next_pend;
  logic [1:0]       rep_bits;
  logic [1:0]       rep_vld;
  logic [3:0]       nbits;
  logic             par;

  // lowest numbered framed port is the receiving port
  always_comb begin
    rx_onehot = '0;
    rx_port   = 2'h0;
    for (int p = PORTS - 1; p >= 0; p--) begin
      if (rx_frame[p]) begin
        rx_onehot = 3'(1 << p);
        rx_port   = 2'(p);
      end
    end
  end

  assign rx_busy = |rx_frame;

  always_comb begin
    par           = 1'b0;
    next_rx_speed = rx_speed;
    cur_speed     = rx_speed;
    next_prev_par = prev_par;
    next_dreg     = dreg;
    next_dcnt     = dcnt;
    next_hold     = hold;
    next_pend     = pend;
    rep_bits      = '0;
    rep_vld       = '0;
    // speed of the next packet taken from tpa common mode at its start
    if (rx_busy && !rx_busy_q) begin
      cur_speed     = tpa_cm[2*rx_port +: 2];
      next_rx_speed = cur_speed;
      next_prev_par = 1'b0;
      next_dcnt     = 4'h0;
    end
    nbits = word_bits(cur_speed);
    // word handed to the link on each rising system clock edge
    if (sys_tick)
      next_pend = 1'b0;
    if (rx_busy) begin
      for (int l = 0; l < LANES; l++) begin
        // a new bit when data xor strobe changes parity
        par = rx_d[2*rx_port + l] ^ rx_s[2*rx_port + l];
        if (par != next_prev_par) begin
          next_prev_par = par;
          rep_bits[l]   = rx_d[2*rx_port + l];
          rep_vld[l]    = 1'b1;
          next_dreg     = {next_dreg[6:0], rx_d[2*rx_port + l]};
          next_dcnt     = next_dcnt + 4'h1;
          if (next_dcnt == nbits) begin
            next_hold = next_dreg << (4'h8 - nbits);
            next_pend = 1'b1;
            next_dcnt = 4'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_busy_q <= 1'b0;
      prev_par  <= 1'b0;
      rx_speed  <= SPD_S100;
      dreg      <= '0;
      dcnt      <= '0;
      hold      <= '0;
      pend      <= 1'b0;
    end else begin
      rx_busy_q <= rx_busy;
      prev_par  <= next_prev_par;
      rx_speed  <= next_rx_speed;
      dreg      <= next_dreg;
      dcnt      <= next_dcnt;
      hold      <= next_hold;
      pend      <= next_pend;
    end
  end

  // ==========================================================
  // transmit: DEPTH-entry buffer (2 or 4), serializer, data-strobe encoder
  cpd_word_type     buf_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic [PTR_W:0]   next_count;
  logic             push;
  logic             pop;
  logic [7:0]       sreg;
  logic [7:0]       next_sreg;
  logic [3:0]       sleft;
  logic [3:0]       next_sleft;
  logic [1:0]       sspeed;
  logic [1:0]       next_sspeed;
  logic             prev_d;
  logic             prev_s;
  logic             next_prev_d;
  logic             next_prev_s;
  cpd_lane_type     lanes;
  logic [1:0]       raw_d;
  logic [1:0]       raw_v;
  logic             emit;

  // link word latched on the system clock while the buffer has room
  assign push = sys_tick & ltx_en & (count != FULL);
  // serializer stalls while a packet is being repeated
  assign pop  = (count != '0) & (sleft == 4'h0) & ~rx_busy & ~pd;

  always_comb begin
    next_count  = count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    next_sreg   = sreg;
    next_sleft  = sleft;
    next_sspeed = sspeed;
    raw_d       = '0;
    raw_v       = '0;
    emit        = slot_tick & (sspeed != SPD_S100 || half);
    if (pop) begin
      next_sreg   = buf_mem[rd_ptr].data;
      next_sspeed = buf_mem[rd_ptr].speed;
      next_sleft  = word_bits(buf_mem[rd_ptr].speed);
    end else if (sleft != 4'h0 && emit && !rx_busy) begin
      // msb first, two bits per slot at the top speed
      raw_d[0] = sreg[7];
      raw_v[0] = 1'b1;
      if (sspeed == SPD_S400) begin
        raw_d[1]   = sreg[6];
        raw_v[1]   = 1'b1;
        next_sreg  = {sreg[5:0], 2'b00};
        next_sleft = sleft - 4'h2;
      end else begin
        next_sreg  = {sreg[6:0], 1'b0};
        next_sleft = sleft - 4'h1;
      end
    end
    if (rx_busy) begin
      raw_d = rep_bits;
      raw_v = rep_vld;
    end
    // strobe toggles whenever data repeats its previous bit
    next_prev_d = prev_d;
    next_prev_s = prev_s;
    lanes       = '0;
    for (int l = 0; l < LANES; l++) begin
      if (raw_v[l]) begin
        if (raw_d[l] == next_prev_d)
          next_prev_s = ~next_prev_s;
        next_prev_d   = raw_d[l];
        lanes.data[l] = raw_d[l];
        lanes.strb[l] = next_prev_s;
        lanes.vld[l]  = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      sreg   <= '0;
      sleft  <= '0;
      sspeed <= SPD_S100;
      prev_d <= 1'b0;
      prev_s <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        buf_mem[i] <= '0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr] <= '{data: ltx_data,
                             speed: cpd_speed_type'(ltx_speed)};
        wr_ptr <= PTR_W'(wr_ptr + 1'b1);
      end
      if (pop)
        rd_ptr <= PTR_W'(rd_ptr + 1'b1);
      count  <= next_count;
      sreg   <= next_sreg;
      sleft  <= next_sleft;
      sspeed <= next_sspeed;
      prev_d <= next_prev_d;
      prev_s <= next_prev_s;
    end
  end

  // ==========================================================
  // output stage: every output comes from a flop
  logic [7:0]         plain_data;
  logic               plain_valid;
  logic [7:0]         next_plain_data;
  logic               next_plain_valid;
  logic [PORTS-1:0]   drive_en;
  logic [2*PORTS-1:0] next_arb;
  logic               tx_on;

  always_comb begin
    next_plain_data  = plain_data;
    next_plain_valid = plain_valid;
    if (sys_tick) begin
      next_plain_data  = pend ? hold : 8'h00;
      next_plain_valid = pend;
    end
    tx_on    = rx_busy | (sleft != 4'h0) | (count != '0);
    // transmitters on connected ports, never on the receiving one
    drive_en = (pd || !tx_on) ? 3'h0 : (tpb_bias & ~rx_onehot);
    for (int p = 0; p < PORTS; p++)
      next_arb[2*p +: 2] = arb_decode(tpa_line[2*p +: 2],
                                      tpb_line[2*p +: 2]);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      plain_data    <= '0;
      plain_valid   <= 1'b0;
      SYSCLK        <= 1'b0;
      LINK_TX_READY <= 1'b0;
      LINK_RX_DATA  <= '0;
      LINK_RX_VALID <= 1'b0;
      LINK_RX_SPEED <= SPD_S100;
      TPB_DATA_O    <= '0;
      TPA_STRB_O    <= '0;
      TX_LANE_VLD   <= '0;
      TPA_OE        <= '0;
      TPB_OE        <= '0;
      TPBIAS_EN     <= '0;
      CONNECTED     <= '0;
      ARB_STATUS    <= '0;
    end else begin
      plain_data    <= next_plain_data;
      plain_valid   <= next_plain_valid;
      SYSCLK        <= next_sysclk;
      LINK_TX_READY <= (next_count != FULL) & ~pd;
      // edges only when coupled through an isolation barrier
      LINK_RX_DATA  <= iso ? next_plain_data
                           : next_plain_data ^ plain_data;
      LINK_RX_VALID <= iso ? next_plain_valid
                           : next_plain_valid ^ plain_valid;
      LINK_RX_SPEED <= rx_speed;
      TPB_DATA_O    <= lanes.data;
      TPA_STRB_O    <= lanes.strb;
      TX_LANE_VLD   <= lanes.vld;
      TPA_OE        <= drive_en;
      TPB_OE        <= drive_en;
      TPBIAS_EN     <= pd ? 3'h0 : bias_en;
      CONNECTED     <= tpb_bias;
      ARB_STATUS    <= next_arb;
    end
  end

endmodule

/* cpd_pkg.sv */
// package: constants, types and helpers of the cable phy datapath
package cpd_pkg;

  // ==========================================================
  // clocking
  localparam longint unsigned REF_HZ    = 24576000;
  localparam longint unsigned PLL_MULT  = 16;
  localparam longint unsigned PLL_HZ    = REF_HZ * PLL_MULT;
  localparam longint unsigned SYSCLK_HZ = PLL_HZ / 8;
  localparam longint unsigned SLOT_HZ   = PLL_HZ / 2;
  localparam longint unsigned CLK_HZ    = 200000000;
  localparam int              NCO_W     = 16;
  // phase steps: sysclk half periods and line bit slots per clk
  localparam logic [NCO_W-1:0] SYS_INC  =
    NCO_W'(((2 * SYSCLK_HZ) << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] SLOT_INC =
    NCO_W'((SLOT_HZ << NCO_W) / CLK_HZ);

  // ==========================================================
  // line rates, bits per second
  localparam longint unsigned S100_BPS = 98304000;
  localparam longint unsigned S200_BPS = 196608000;
  localparam longint unsigned S400_BPS = 392216000;

  // ==========================================================
  // ports and lanes
  localparam int PORTS = 3;
  localparam int LANES = 2;
  localparam int WORD_W = 8;
  localparam logic [3:0] BITS_S100 = 4'h2;
  localparam logic [3:0] BITS_S200 = 4'h4;
  localparam logic [3:0] BITS_S400 = 4'h8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SPD_S100 = 2'b00,
    SPD_S200 = 2'b01,
    SPD_S400 = 2'b10
  } cpd_speed_type;

  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b00,
    ARB_REQ   = 2'b01,
    ARB_GRANT = 2'b10,
    ARB_OTHER = 2'b11
  } cpd_arb_type;

  // comparator line state codes
  localparam logic [1:0] LS_Z   = 2'h0;
  localparam logic [1:0] LS_LOW = 2'h1;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    cpd_speed_type     speed;
  } cpd_word_type;

  typedef struct packed {
    logic [LANES-1:0] data;
    logic [LANES-1:0] strb;
    logic [LANES-1:0] vld;
  } cpd_lane_type;

  // ==========================================================
  // helpers
  function automatic logic [3:0] word_bits(input logic [1:0] spd);
    unique case (spd)
      SPD_S100: word_bits = BITS_S100;
      SPD_S200: word_bits = BITS_S200;
      default:  word_bits = BITS_S400;
    endcase
  endfunction

  function automatic cpd_arb_type arb_decode(input logic [1:0] a,
                                             input logic [1:0] b);
    if (a == LS_Z && b == LS_Z)
      arb_decode = ARB_IDLE;
    else if (a == LS_Z && b == LS_LOW)
      arb_decode = ARB_REQ;
    else if (a == LS_LOW && b == LS_Z)
      arb_decode = ARB_GRANT;
    else
      arb_decode = ARB_OTHER;
  endfunction

endpackage

/* cpd_link_model.sv */
// model: link-layer controller on the parallel data side
`timescale 1ns/100ps
module cpd_link_model
  import cpd_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              ISO_SELECT,
  input  wire logic              SYSCLK,
  input  wire logic              LINK_TX_READY,
  input  wire logic [WORD_W-1:0] LINK_RX_DATA,
  input  wire logic              LINK_RX_VALID,
  output logic                   LINK_TX_EN,
  output logic [WORD_W-1:0]      LINK_TX_DATA,
  output logic [1:0]             LINK_TX_SPEED
);
  logic [9:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic       sys_q;
  logic       vld_q;
  logic [7:0] dacc;
  logic       vacc;
  logic [7:0] rxd;
  logic       rxv;

  // undo the edge coding when the isolation barrier is selected
  assign rxd = ISO_SELECT ? LINK_RX_DATA : dacc ^ LINK_RX_DATA;
  assign rxv = ISO_SELECT ? LINK_RX_VALID : vacc ^ LINK_RX_VALID;

  // queue a word with its speed for transmission
  task automatic push(input logic [1:0] spd, input logic [7:0] w);
    tx_q.push_back({spd, w});
  endtask

  // one word per link clock period; received words taken on valid
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sys_q <= 1'b0;
      vld_q <= 1'b0;
      dacc <= 8'h00;
      vacc <= 1'b0;
      LINK_TX_EN <= 1'b0;
      LINK_TX_DATA <= 8'h00;
      LINK_TX_SPEED <= 2'h0;
    end else begin
      sys_q <= SYSCLK;
      vld_q <= rxv;
      dacc <= rxd;
      vacc <= rxv;
      if (rxv && !vld_q)
        rx_q.push_back(rxd);
      if (SYSCLK && !sys_q) begin
        if (tx_q.size() > 0 && LINK_TX_READY) begin
          {LINK_TX_SPEED, LINK_TX_DATA} <= tx_q.pop_front();
          LINK_TX_EN <= 1'b1;
        end else begin
          LINK_TX_EN <= 1'b0;
          LINK_TX_DATA <= ~LINK_TX_DATA; // released lines keep no value
        end
      end
    end
  end
endmodule

/* cpd_datapath_sva.sv */
// checker: port assertions of the cable phy datapath
`timescale 1ns/100ps
module cpd_datapath_sva
  import cpd_pkg::*;
(
  input wire logic             CLK,
  input wire logic             RESETN,
  input wire logic             POWER_DOWN_INPUT,
  input wire logic [PORTS-1:0] BIAS_ENABLE,
  input wire logic [PORTS-1:0] RX_FRAME_I,
  input wire logic [PORTS-1:0] TPB_BIAS_I,
  input wire logic             SYSCLK,
  input wire logic             LINK_RX_VALID,
  input wire logic [LANES-1:0] TPB_DATA_O,
  input wire logic [LANES-1:0] TPA_STRB_O,
  input wire logic [LANES-1:0] TX_LANE_VLD,
  input wire logic [PORTS-1:0] TPA_OE,
  input wire logic [PORTS-1:0] TPB_OE,
  input wire logic [PORTS-1:0] TPBIAS_EN,
  input wire logic [PORTS-1:0] CONNECTED
);
  logic [PORTS-1:0] fr1;
  logic [PORTS-1:0] fr2;
  logic [PORTS-1:0] fr3;
  logic [PORTS-1:0] fr_hold;
  logic             sys_q;
  logic [3:0]       since_rise;
  logic [3:0]       run_cnt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ==========================================================
  // helper logic
  // frame history and cycles since the last link clock rise
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fr1 <= '0;
      fr2 <= '0;
      fr3 <= '0;
      sys_q <= 1'b0;
      since_rise <= 4'h0;
      run_cnt <= 4'h0;
    end else begin
      // cycles with power-down low, saturating at twelve
      if (POWER_DOWN_INPUT)
        run_cnt <= 4'h0;
      else if (run_cnt != 4'hC)
        run_cnt <= run_cnt + 4'h1;
      fr1 <= RX_FRAME_I;
      fr2 <= fr1;
      fr3 <= fr2;
      sys_q <= SYSCLK;
      if (SYSCLK && !sys_q)
        since_rise <= 4'h0;
      else if (since_rise != 4'hF)
        since_rise <= since_rise + 4'h1;
    end
  end
  assign fr_hold = RX_FRAME_I & fr1 & fr2 & fr3;

  // ==========================================================
  // assertions
  AST_BIAS_FOLLOWS: assert property (
    ($stable(BIAS_ENABLE) && !POWER_DOWN_INPUT)[*5]
      |-> TPBIAS_EN == BIAS_ENABLE)
    else $error("bias output differs from its enable");
  AST_CONNECT_FOLLOWS: assert property (
    ($stable(TPB_BIAS_I) && !POWER_DOWN_INPUT)[*5]
      |-> CONNECTED == TPB_BIAS_I)
    else $error("connection flag differs from remote bias");
  AST_RX_PORT_QUIET: assert property (
    |fr_hold |-> ((TPA_OE | TPB_OE) & fr_hold) == '0)
    else $error("receiving port drives its pairs");
  AST_PD_STOPS_CLOCK: assert property (
    POWER_DOWN_INPUT[*6] |-> $stable(SYSCLK))
    else $error("link clock runs in power-down");
  AST_SYSCLK_SPACING: assert property (
    $rose(SYSCLK) |=> (!$rose(SYSCLK))[*3])
    else $error("link clock period too short");
  AST_SYSCLK_RUNS: assert property (
    run_cnt == 4'hC |-> since_rise <= 4'h5)
    else $error("link clock period too long");
  AST_STROBE_PAIR: assert property (
    TX_LANE_VLD == 2'b11 |->
      (TPB_DATA_O[0] ^ TPA_STRB_O[0]) != (TPB_DATA_O[1] ^ TPA_STRB_O[1]))
    else $error("strobe does not alternate parity");
  AST_OE_CONNECTED: assert property (
    ((TPA_OE | TPB_OE) & ~(CONNECTED | $past(CONNECTED))) == '0)
    else $error("unconnected port driven");

  // main scenarios reached
  COV_RX_WORD: cover property ($rose(LINK_RX_VALID));
  COV_TWO_LANES: cover property (TX_LANE_VLD == 2'b11);
  COV_PD_HALT: cover property (POWER_DOWN_INPUT[*6]);
endmodule

bind cpd_datapath cpd_datapath_sva u_sva (.*);

/* test_cpd_datapath.sv */
// testbench: directed scenarios for the cable phy datapath
`timescale 1ns/100ps
module test_cpd_datapath;
  import cpd_pkg::*;
  logic CLK, RESETN, POWER_DOWN_INPUT, ISO_SELECT, LINK_TX_EN;
  logic SYSCLK, LINK_TX_READY, LINK_RX_VALID;
  logic [PORTS-1:0] BIAS_ENABLE, RX_FRAME_I, TPB_BIAS_I;
  logic [PORTS-1:0] TPA_OE, TPB_OE, TPBIAS_EN, CONNECTED;
  logic [2*PORTS-1:0] TPA_DATA_I, TPB_STRB_I, TPA_LINE_I, TPB_LINE_I;
  logic [2*PORTS-1:0] TPA_CM_I, ARB_STATUS;
  logic [WORD_W-1:0] LINK_TX_DATA, LINK_RX_DATA;
  logic [1:0] LINK_TX_SPEED, LINK_RX_SPEED;
  logic [LANES-1:0] TPB_DATA_O, TPA_STRB_O, TX_LANE_VLD;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic bq[$];
  logic oe_seen = 1'b0;

  cpd_datapath DUT (.*);
  cpd_link_model link (.*);

  // 200 MHz clock
  initial CLK = 1'b0;
  always #2.5 CLK = ~CLK;

  // collect line bits, watch port 1 drivers, cut a hang short
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      final_report();
    end
    for (int l = 0; l < LANES; l++)
      if (TX_LANE_VLD[l] === 1'b1)
        bq.push_back(TPB_DATA_O[l]);
    if (TPA_OE[1] === 1'b1 && TPB_OE[1] === 1'b1)
      oe_seen = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  function automatic int nbits(input logic [1:0] s);
    return (s == SPD_S100) ? 2 : (s == SPD_S200) ? 4 : 8;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d in %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // link clock rises counted over 400 cycles
  task automatic t_rate();
    int   r = 0;
    int   e = int'(400 * SYSCLK_HZ / CLK_HZ);
    logic q = SYSCLK;
    repeat (400) begin
      @(posedge CLK);
      r += int'(SYSCLK && !q);
      q = SYSCLK;
    end
    check(r >= e && r <= e + 1, 1'b1);
  endtask

  // four comparator code pairs, one per arbitration status, on all ports
  task automatic t_arb();
    logic [1:0] a[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] b[4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    for (int i = 0; i < 4; i++) begin
      TPA_LINE_I <= {3{a[i]}};
      TPB_LINE_I <= {3{b[i]}};
      cyc(6);
      check(ARB_STATUS, {3{i[1:0]}});
    end
    TPA_LINE_I <= '0;
    TPB_LINE_I <= '0;
  endtask

  // per-port bias outputs and remote bias detection
  task automatic t_bias();
    BIAS_ENABLE <= 3'b101;
    TPB_BIAS_I <= 3'b010;
    cyc(6);
    check(TPBIAS_EN, 3'b101);
    check(CONNECTED, 3'b010);
    BIAS_ENABLE <= 3'b010;
    TPB_BIAS_I <= 3'b110;
    cyc(6);
    check(TPBIAS_EN, 3'b010);
    check(CONNECTED, 3'b110);
  endtask

  // a 16-bit packet into port 0, then the words and the repeat
  task automatic t_rx(input logic [1:0] spd, input logic iso);
    logic [15:0] v = 16'hB4E1;
    int          n = nbits(spd);
    int          h = 16 / n + 1;
    logic        par = 1'b0;
    logic [7:0]  m = 8'hFF << (8 - n);
    logic [15:0] e;
    logic [15:0] got = '0;
    bq.delete();
    link.rx_q.delete();
    oe_seen = 1'b0;
    TPA_CM_I <= {3{spd}};
    cyc(4);
    RX_FRAME_I <= 3'b001;
    cyc(4);
    for (int i = 15; i >= 0; i--) begin
      par = ~par;
      TPA_DATA_I <= {6{v[i]}};
      TPB_STRB_I <= {6{v[i] ^ par}};
      cyc(h);
    end
    cyc(20);
    RX_FRAME_I <= 3'b000;
    cyc(4);
    check(link.rx_q.size(), 16 / n);
    for (int w = 0; w < link.rx_q.size(); w++) begin
      e = ((v << (n * w)) >> 8) & m;
      check(link.rx_q[w] & m, e);
    end
    check(LINK_RX_SPEED, spd);
    foreach (bq[i])
      if (i < 16)
        got[15 - i] = bq[i];
    check(bq.size(), 16);
    check(got, v);
    check(oe_seen, 1'b1);
  endtask

  // one link word out on the line lanes, msb first
  task automatic t_tx(input logic [1:0] spd, input logic [7:0] w);
    int         n = nbits(spd);
    logic [7:0] got = 8'h00;
    bq.delete();
    link.push(spd, w);
    cyc(60);
    check(bq.size(), n);
    for (int i = 0; i < n && i < bq.size(); i++)
      got[7 - i] = bq[i];
    check(got, w & (8'hFF << (8 - n)));
  endtask

  // power-down freezes the link clock
  task automatic t_pd();
    logic s;
    POWER_DOWN_INPUT <= 1'b1;
    cyc(6);
    s = SYSCLK;
    cyc(20);
    check(SYSCLK, s);
    check(LINK_TX_READY, 1'b0);
    POWER_DOWN_INPUT <= 1'b0;
    cyc(12);
    check(LINK_TX_READY, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    RESETN = 1'b0;
    POWER_DOWN_INPUT = 1'b0;
    ISO_SELECT = 1'b1;
    BIAS_ENABLE = '0;
    RX_FRAME_I = '0;
    TPB_BIAS_I = '0;
    TPA_DATA_I = '0;
    TPB_STRB_I = '0;
    TPA_LINE_I = '0;
    TPB_LINE_I = '0;
    TPA_CM_I = '0;
    cyc(6);
    RESETN <= 1'b1;
    cyc(4);
    t_rate();
    t_arb();
    t_bias();
    for (int s = 0; s < 3; s++)
      t_rx(2'(s), 1'b0);
    ISO_SELECT <= 1'b0;
    cyc(4);
    t_rx(SPD_S400, 1'b1);
    ISO_SELECT <= 1'b1;
    cyc(4);
    for (int s = 0; s < 3; s++)
      t_tx(2'(s), 8'h9C);
    t_pd();
    final_report();
  end
endmodule
